/* File: tb/rtcc_checker_assertions.sv */
// Purpose: port checks of the compensation and control block
// Assumes: one clock, async active-low reset
// Notes:   sees top-level ports only
`timescale 1ns/1ps
// ====================================================
// checker
module rtcc_checker (
    // clock and reset
    input wire logic                sys_clk,
    input wire logic                rst_n,
    // register port
    input wire rtcc_pkg::rtcc_req_s bus_req,
    input wire logic [31:0]         bus_rdata,
    input wire logic                bus_error,
    // oscillator and pin
    input wire logic                osc_32k,
    input wire logic                osc_enable,
    input wire logic [3:0]          osc_load_sel,
    input wire logic                clk32_fwd,
    input wire logic                wakeup_o
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    // read data only in the slot after a read
    rdata_slot_a: assert property (!$past(bus_req.rd) |-> bus_rdata == 32'h0)
        else $error("read data outside its slot");
    read_no_error_a: assert property ($past(bus_req.rd) |-> !bus_error)
        else $error("error after a read");
    error_cause_a: assert property (bus_error |->
        $past(bus_req.wr) && !$past(bus_req.supervisor))
        else $error("error without a user write");
    // outputs move only two cycles after a control write
    load_by_write_a: assert property ($changed(osc_load_sel) |->
        $past(bus_req.wr, 2) && $past(bus_req.addr, 2) == 8'h10)
        else $error("load select moved without write");
    osc_by_write_a: assert property ($changed(osc_enable) |->
        $past(bus_req.wr, 2) && $past(bus_req.addr, 2) == 8'h10)
        else $error("osc enable moved without write");
    fwd_off_a: assert property (!osc_enable && !$past(osc_enable) |-> !clk32_fwd)
        else $error("clock forwarded with osc off");
    // sampled level plus output register: two cycles behind the pin
    fwd_source_a: assert property ($rose(clk32_fwd) |-> $past(osc_32k, 2))
        else $error("forwarded clock not from osc");
    wake_clock_a: assert property (wakeup_o |-> osc_enable || $past(osc_enable))
        else $error("wakeup high without clock");
endmodule // rtcc_checker

bind rtcc_top rtcc_checker rtcc_checker_i (
    .sys_clk      (sys_clk),
    .rst_n        (rst_n),
    .bus_req      (bus_req),
    .bus_rdata    (bus_rdata),
    .bus_error    (bus_error),
    .osc_32k      (osc_32k),
    .osc_enable   (osc_enable),
    .osc_load_sel (osc_load_sel),
    .clk32_fwd    (clk32_fwd),
    .wakeup_o     (wakeup_o)
);

/* File: tb/rtcc_osc_model.sv */
// Purpose: crystal oscillator seen by the block
// Assumes: output synchronous to sys_clk
// Notes:   fastest legal rate keeps seconds short
`timescale 1ns/1ps
// ====================================================
// oscillator
module rtcc_osc_model #(
    parameter int STARTUP = 16
) (
    // clock
    input  wire logic sys_clk,
    // enable from the block
    input  wire logic osc_enable,
    // oscillator level
    output logic      osc_32k
);
    int warm_reg = 0;
    initial osc_32k = 1'b0;
    // held low until warmed up, so early counting shows
    always @(posedge sys_clk)
    begin
        if (!osc_enable)
        begin
            warm_reg <= 0;
            osc_32k  <= 1'b0;
        end
        else if (warm_reg < STARTUP)
            warm_reg <= warm_reg + 1;
        else
            osc_32k <= !osc_32k;
    end
endmodule // rtcc_osc_model

/* File: tb/rtcc_top_tb.sv */
// Purpose: self-checking bench of the compensation and control block
// Assumes: oscillator model at the osc pins
// Notes:   seconds shortened by presetting the prescaler
`timescale 1ns/1ps
`include "rtcc_cfg.svh"
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin bad_count++; \
    $display("MISMATCH %s exp %h got %h", n, e, s); end end
// ====================================================
// bench
module rtcc_top_tb;
    localparam int STARTUP = 16;
    logic                sys_clk = 1'b0;
    logic                rst_n   = 1'b0;
    rtcc_pkg::rtcc_req_s rq      = '0;
    logic                turn_on = 1'b0;
    logic [31:0]         bus_rdata;
    logic [31:0]         rd_val;
    logic [3:0]          osc_load_sel;
    logic                bus_error, osc_32k, osc_enable, clk32_fwd;
    logic                wakeup_o, wakeup_oe, irq, err_seen;
    int                  bad_count   = 0;
    int                  check_count = 0;
    int                  tick_n      = 0;
    int                  t0;

    rtcc_top rtcc_top_i (
        .sys_clk        (sys_clk),
        .rst_n          (rst_n),
        .bus_req        (rq),
        .bus_rdata      (bus_rdata),
        .bus_error      (bus_error),
        .osc_32k        (osc_32k),
        .osc_enable     (osc_enable),
        .osc_load_sel   (osc_load_sel),
        .clk32_fwd      (clk32_fwd),
        .wakeup_turn_on (turn_on),
        .wakeup_o       (wakeup_o),
        .wakeup_oe      (wakeup_oe),
        .irq            (irq)
    );
    rtcc_osc_model #(.STARTUP(STARTUP)) rtcc_osc_model_i (
        .sys_clk    (sys_clk),
        .osc_enable (osc_enable),
        .osc_32k    (osc_32k)
    );

    // 20 MHz clock and oscillator cycle count
    always #25 sys_clk = ~sys_clk;
    always @(posedge osc_32k) tick_n++;

    task automatic finish_test;
        if (bad_count == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // hang guard, well above the one long second
    initial
    begin
        #4500000;
        bad_count++;
        finish_test();
    end

    task automatic do_reset;
        @(posedge sys_clk);
        rst_n <= 1'b0;
        repeat (16) @(posedge sys_clk);
        rst_n <= 1'b1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic s = 1'b1);
        @(posedge sys_clk);
        rq <= '{rd: 1'b0, wr: 1'b1, supervisor: s, addr: a, wdata: d};
        @(posedge sys_clk);
        rq.wr <= 1'b0;
        #1 err_seen = bus_error;
    endtask
    task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e);
        @(posedge sys_clk);
        rq <= '{rd: 1'b1, wr: 1'b0, supervisor: 1'b1, addr: a, wdata: 32'h0};
        @(posedge sys_clk);
        rq.rd <= 1'b0;
        #1 rd_val = bus_rdata;
        `CHK(n, e, rd_val)
    endtask
    task automatic settle(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    task automatic fwd_seen(input string n, input logic e);
        logic seen;
        seen = 1'b0;
        repeat (8)
        begin
            @(negedge sys_clk);
            seen |= clk32_fwd;
        end
        `CHK(n, e, seen)
    endtask
    task automatic wait_irq;
        // a clear that just landed needs two edges to drop irq
        settle(2);
        for (int i = 0; i < 70000 && irq !== 1'b1; i++)
            @(negedge sys_clk);
        `CHK("irq", 1'b1, irq)
    endtask
    // short second: stop, preset near the boundary, restart
    task automatic sec_fast;
        wr(`RTCC_OFS_STATUS, 32'h0);
        wr(`RTCC_OFS_SECONDS, 32'h0);
        wr(`RTCC_OFS_PRESCALER, 32'h7ffe);
        wr(`RTCC_OFS_IRQ_CLR, 32'h7);
        wr(`RTCC_OFS_STATUS, 32'h10);
        wait_irq();
    endtask

    task automatic t_reset_vals;
        rchk("ctrl", `RTCC_OFS_CTRL, 32'h0);
        rchk("comp", `RTCC_OFS_COMP, 32'h0);
        rchk("status", `RTCC_OFS_STATUS, 32'h1);
        rchk("lock", `RTCC_OFS_LOCK, 32'hff);
        rchk("unmapped", 8'h3c, 32'h0);
    endtask
    task automatic t_ctrl;
        wr(`RTCC_OFS_CTRL, 32'hffff_bffe);
        rchk("ctrl_rsv", `RTCC_OFS_CTRL, 32'h0000_3f1e);
        `CHK("load_all", 4'hf, osc_load_sel)
        `CHK("osc_on", 1'b1, osc_enable)
        `CHK("oe_gated", 1'b0, wakeup_oe)
        wr(`RTCC_OFS_CTRL, 32'h0000_2116);
        settle(STARTUP + 2);
        `CHK("load_2pf", 4'h8, osc_load_sel)
        `CHK("oe_clk", 1'b1, wakeup_oe)
        fwd_seen("fwd_on", 1'b1);
        wr(`RTCC_OFS_CTRL, 32'h0000_2316);
        settle(2);
        fwd_seen("fwd_off", 1'b0);
        wr(`RTCC_OFS_CTRL, 32'h0000_0102);
        @(posedge sys_clk);
        turn_on <= 1'b1;
        settle(3);
        `CHK("oe_on", 1'b1, wakeup_oe)
        `CHK("o_low", 1'b0, wakeup_o)
        @(posedge sys_clk);
        turn_on <= 1'b0;
        settle(3);
        `CHK("oe_off", 1'b0, wakeup_oe)
    endtask
    // supervisor bit now clear: user write must bounce
    task automatic t_sup;
        wr(`RTCC_OFS_CTRL, 32'h0000_0300, 1'b0);
        `CHK("user_err", 1'b1, err_seen)
        rchk("ctrl_kept", `RTCC_OFS_CTRL, 32'h0000_0102);
        wr(`RTCC_OFS_CTRL, 32'h0000_0104);
        wr(`RTCC_OFS_CTRL, 32'h0000_0304, 1'b0);
        `CHK("user_ok", 1'b0, err_seen)
        rchk("ctrl_user", `RTCC_OFS_CTRL, 32'h0000_0304);
        @(posedge sys_clk);
        turn_on <= 1'b1;
        settle(3);
        `CHK("pin_off", 1'b0, wakeup_oe)
        @(posedge sys_clk);
        turn_on <= 1'b0;
    endtask
    task automatic t_soft;
        wr(`RTCC_OFS_SECONDS, 32'h0);
        wr(`RTCC_OFS_CTRL, 32'h0000_0101);
        rchk("swr_ctrl", `RTCC_OFS_CTRL, 32'h1);
        rchk("swr_stat", `RTCC_OFS_STATUS, 32'h1);
        `CHK("swr_osc", 1'b0, osc_enable)
        wr(`RTCC_OFS_CTRL, 32'h0);
        rchk("swr_clr", `RTCC_OFS_CTRL, 32'h0);
    endtask
    task automatic t_lock;
        wr(`RTCC_OFS_LOCK, 32'h0000_00df);
        wr(`RTCC_OFS_STATUS, 32'h10);
        rchk("um0_stat", `RTCC_OFS_STATUS, 32'h1);
        wr(`RTCC_OFS_CTRL, 32'h8);
        wr(`RTCC_OFS_STATUS, 32'h10);
        rchk("um1_stat", `RTCC_OFS_STATUS, 32'h11);
        wr(`RTCC_OFS_LOCK, 32'h0000_00cf);
        wr(`RTCC_OFS_CTRL, 32'h100);
        rchk("ctrl_lock", `RTCC_OFS_CTRL, 32'h8);
    endtask
    // a short second to load the values, one full compensated second, then short ones
    task automatic t_comp;
        wr(`RTCC_OFS_CTRL, 32'h100);
        settle(STARTUP + 4);
        wr(`RTCC_OFS_COMP, 32'haabb_017f);
        rchk("comp_ro", `RTCC_OFS_COMP, 32'h0000_017f);
        wr(`RTCC_OFS_IRQ_EN, 32'h2);
        sec_fast();
        t0 = tick_n;
        rchk("comp_b1", `RTCC_OFS_COMP, 32'h017f_017f);
        wr(`RTCC_OFS_COMP, 32'h0000_0005);
        rchk("comp_buf", `RTCC_OFS_COMP, 32'h017f_0005);
        wr(`RTCC_OFS_IRQ_CLR, 32'h2);
        wait_irq();
        `CHK("period", 32641, tick_n - t0)
        rchk("comp_b2", `RTCC_OFS_COMP, 32'h0000_0005);
        sec_fast();
        rchk("comp_b3", `RTCC_OFS_COMP, 32'h0005_0005);
        wr(`RTCC_OFS_IRQ_CLR, 32'h2);
        rchk("irq_stat", `RTCC_OFS_IRQ_STAT, 32'h4);
        `CHK("irq_mask", 1'b0, irq)
        sec_fast();
        rchk("comp_b4", `RTCC_OFS_COMP, 32'h0005_0005);
    endtask

    // main sequence
    initial
    begin
        do_reset();
        t_reset_vals();
        t_ctrl();
        t_sup();
        t_soft();
        t_lock();
        do_reset();
        t_comp();
        finish_test();
    end
endmodule // rtcc_top_tb

/* File: verilog/rtcc_cfg.svh */
// Purpose: register map, field positions, reset values and counts
// Assumes: byte addresses on a 32-bit register port
// Notes:   definitions only
`ifndef RTCC_CFG_SVH
`define RTCC_CFG_SVH
// =====================================================================
// offsets
`define RTCC_OFS_SECONDS   8'h00
`define RTCC_OFS_PRESCALER 8'h04
`define RTCC_OFS_COMP      8'h0c
`define RTCC_OFS_CTRL      8'h10
`define RTCC_OFS_STATUS    8'h14
`define RTCC_OFS_LOCK      8'h18
`define RTCC_OFS_IRQ_STAT  8'h20
`define RTCC_OFS_IRQ_EN    8'h24
`define RTCC_OFS_IRQ_CLR   8'h28
// =====================================================================
// control fields
`define RTCC_CTRL_SWR      0
`define RTCC_CTRL_WPE      1
`define RTCC_CTRL_SUP      2
`define RTCC_CTRL_UM       3
`define RTCC_CTRL_WPS      4
`define RTCC_CTRL_OSCILLATOR_ENABLE     8
`define RTCC_CTRL_GATE     9
`define RTCC_CTRL_LOAD_LSB 10
// compensation fields
`define RTCC_COMP_VAL_LSB  0
`define RTCC_COMP_INT_LSB  8
`define RTCC_COMP_CUR_LSB  16
`define RTCC_COMP_CIC_LSB  24
// status and lock fields
`define RTCC_ST_TIF        0
`define RTCC_ST_TOF        1
`define RTCC_ST_TCE        4
`define RTCC_LK_COMP       3
`define RTCC_LK_CTRL       4
`define RTCC_LK_STAT       5
`define RTCC_LK_LOCK       6
// =====================================================================
// reset values and counts
`define RTCC_LOCK_RST      8'hff
`define RTCC_PRESC_CYCLES  32768
`endif

/* File: verilog/rtcc_pkg.sv */
// Purpose: shared types of the clock compensation and control block
// Assumes: nothing
// Notes:   constants live in rtcc_cfg.svh
package rtcc_pkg;
    // =================================================================
    // control register image, bit 31 down to 0
    typedef struct packed {
        logic [17:0] zero_hi;
        logic [3:0]  load_caps;        // 2, 4, 8, 16 pF enables
        logic        clock_forward_gate;
        logic        oscillator_enable;
        logic [2:0]  zero_mid;
        logic        wakeup_output_select;
        logic        locked_update_mode;
        logic        supervisor_write_only;
        logic        wakeup_pin_enable;
        logic        soft_reset_bit;
    } rtcc_ctrl_s;

    // register port request
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic        supervisor;
        logic [7:0]  addr;
        logic [31:0] wdata;
    } rtcc_req_s;

    // sticky event bits: overflow, second, interval end
    typedef logic [2:0] rtcc_evt_t;
endpackage

/* File: verilog/rtcc_top.sv */
// Purpose: prescaler with compensation, seconds count, control register
// Assumes: osc_32k is a level synchronous to sys_clk (20 MHz)
// Notes:   soft reset holds every register but itself and the control lock bit while set
`timescale 1ns/1ps
`include "rtcc_cfg.svh"

module rtcc_top #(
    parameter int PRESC_W = 16
) (
    // clock and reset
    input  wire logic               sys_clk,
    input  wire logic               rst_n,
    // register port
    input  wire rtcc_pkg::rtcc_req_s bus_req,
    output logic [31:0]             bus_rdata,
    output logic                    bus_error,
    // oscillator
    input  wire logic               osc_32k,
    output logic                    osc_enable,
    output logic [3:0]              osc_load_sel,
    output logic                    clk32_fwd,
    // wakeup pin and interrupt
    input  wire logic               wakeup_turn_on,
    output logic                    wakeup_o,
    output logic                    wakeup_oe,
    output logic                    irq
);
    // =================================================================
    // state
    rtcc_pkg::rtcc_ctrl_s ctrl_reg;
    logic [31:0]          seconds_count;
    logic [PRESC_W-1:0]   prescaler_count;
    logic [7:0]           stall_reg;
    logic [7:0]           comp_interval_setting;
    logic [7:0]           comp_value_setting;
    logic [7:0]           comp_interval_counter;
    logic [7:0]           current_comp_value;
    logic                 counter_enable_status;
    logic                 time_invalid_flag;
    logic                 time_overflow_flag;
    logic [7:0]           lock_reg;
    rtcc_pkg::rtcc_evt_t  irq_stat_reg;
    rtcc_pkg::rtcc_evt_t  irq_en_reg;
    logic                 osc_q;
    logic [31:0]          rdata_next;

    // =================================================================
    // decode and write qualification
    logic soft_rst;
    logic wr_ok;
    logic count_on;
    logic tick;
    logic boundary;
    logic [7:0] comp_next;
    logic stat_wr_allowed;

    assign soft_rst = ctrl_reg.soft_reset_bit;
    // writes from user mode are dropped unless the control register allows
    assign wr_ok    = bus_req.wr
                    & (bus_req.supervisor | ctrl_reg.supervisor_write_only);
    assign count_on = counter_enable_status & ~time_invalid_flag
                    & ~time_overflow_flag;
    // rising edge of the sampled oscillator level is one 32 kHz cycle
    assign tick     = osc_32k & ~osc_q & ctrl_reg.oscillator_enable;
    // bit 14 falls when the low 15 bits roll over
    assign boundary = tick & count_on & (stall_reg == 8'h00)
                    & (prescaler_count[14:0] == 15'h7fff);
    // value for the second that starts now
    assign comp_next = (comp_interval_counter == 8'h00)
                     ? comp_value_setting
                     : 8'h00;
    // locked status: only counter enable, only in update mode, only when safe
    assign stat_wr_allowed = lock_reg[`RTCC_LK_STAT]
                           | (ctrl_reg.locked_update_mode
                              & (time_invalid_flag | time_overflow_flag
                                 | ~counter_enable_status));

    function automatic logic wr_at(input logic [7:0] ofs);
        wr_at = wr_ok & (bus_req.addr == ofs);
    endfunction

    // =================================================================
    // oscillator sampling
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            osc_q <= 1'b0;
        else
            osc_q <= osc_32k;
    end

    // =================================================================
    // control register; while soft reset is set the other bits stay zero
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            ctrl_reg <= '0;
        else if (wr_at(`RTCC_OFS_CTRL) && lock_reg[`RTCC_LK_CTRL])
        begin
            ctrl_reg <= '0;
            ctrl_reg.soft_reset_bit <= bus_req.wdata[`RTCC_CTRL_SWR];
            if (!bus_req.wdata[`RTCC_CTRL_SWR] && !soft_rst)
            begin
                ctrl_reg.load_caps <= bus_req.wdata[`RTCC_CTRL_LOAD_LSB +: 4];
                ctrl_reg.clock_forward_gate    <= bus_req.wdata[`RTCC_CTRL_GATE];
                ctrl_reg.oscillator_enable     <= bus_req.wdata[`RTCC_CTRL_OSCILLATOR_ENABLE];
                ctrl_reg.wakeup_output_select  <= bus_req.wdata[`RTCC_CTRL_WPS];
                ctrl_reg.locked_update_mode    <= bus_req.wdata[`RTCC_CTRL_UM];
                ctrl_reg.supervisor_write_only <= bus_req.wdata[`RTCC_CTRL_SUP];
                ctrl_reg.wakeup_pin_enable     <= bus_req.wdata[`RTCC_CTRL_WPE];
            end
        end
    end

    // =================================================================
    // lock register: bits only clear by write, set again by resets
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            lock_reg <= `RTCC_LOCK_RST;
        else if (soft_rst)
        begin
            // control lock is returned only by power-on reset
            lock_reg <= `RTCC_LOCK_RST;
            lock_reg[`RTCC_LK_CTRL] <= lock_reg[`RTCC_LK_CTRL];
        end
        else if (wr_at(`RTCC_OFS_LOCK) && lock_reg[`RTCC_LK_LOCK])
            lock_reg <= lock_reg & (bus_req.wdata[7:0] | 8'h87);
    end

    // =================================================================
    // compensation settings, double buffered through the interval counter
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            comp_interval_setting <= 8'h00;
            comp_value_setting    <= 8'h00;
        end
        else if (soft_rst)
        begin
            comp_interval_setting <= 8'h00;
            comp_value_setting    <= 8'h00;
        end
        else if (wr_at(`RTCC_OFS_COMP) && lock_reg[`RTCC_LK_COMP])
        begin
            // upper fields are read only, write data there is dropped
            comp_interval_setting <= bus_req.wdata[`RTCC_COMP_INT_LSB +: 8];
            comp_value_setting    <= bus_req.wdata[`RTCC_COMP_VAL_LSB +: 8];
        end
    end

    // interval counter and current value step only at second boundaries
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            comp_interval_counter <= 8'h00;
            current_comp_value    <= 8'h00;
        end
        else if (soft_rst)
        begin
            comp_interval_counter <= 8'h00;
            current_comp_value    <= 8'h00;
        end
        else if (boundary)
        begin
            current_comp_value <= comp_next;
            if (comp_interval_counter == 8'h00)
                comp_interval_counter <= comp_interval_setting;
            else
                comp_interval_counter <= comp_interval_counter - 8'h01;
        end
    end

    // =================================================================
    // prescaler: positive value skips counts, negative value stalls
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            prescaler_count <= '0;
        else if (soft_rst)
            prescaler_count <= '0;
        else if (wr_at(`RTCC_OFS_PRESCALER) && !counter_enable_status)
            prescaler_count <= bus_req.wdata[PRESC_W-1:0];
        else if (boundary && !comp_next[7])
            prescaler_count <= prescaler_count + PRESC_W'(1)
                             + PRESC_W'(comp_next);
        else if (tick && count_on && stall_reg == 8'h00)
            prescaler_count <= prescaler_count + PRESC_W'(1);
    end

    // stall length equals the magnitude of a negative value
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            stall_reg <= 8'h00;
        else if (soft_rst)
            stall_reg <= 8'h00;
        else if (boundary && comp_next[7])
            stall_reg <= 8'h00 - comp_next;
        else if (tick && count_on && stall_reg != 8'h00)
            stall_reg <= stall_reg - 8'h01;
    end

    // =================================================================
    // seconds count, writable only while counting is disabled
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            seconds_count <= 32'h0000_0000;
        else if (soft_rst)
            seconds_count <= 32'h0000_0000;
        else if (wr_at(`RTCC_OFS_SECONDS) && !counter_enable_status)
            seconds_count <= bus_req.wdata;
        else if (boundary)
            seconds_count <= seconds_count + 32'h0000_0001;
    end

    // =================================================================
    // status flags; a seconds write while stopped validates the time
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            time_invalid_flag  <= 1'b1;
            time_overflow_flag <= 1'b0;
        end
        else if (soft_rst)
        begin
            time_invalid_flag  <= 1'b1;
            time_overflow_flag <= 1'b0;
        end
        else if (boundary && seconds_count == 32'hffff_ffff)
            time_overflow_flag <= 1'b1;                            // set beats clear
        else if (wr_at(`RTCC_OFS_SECONDS) && !counter_enable_status)
        begin
            time_invalid_flag  <= 1'b0;
            time_overflow_flag <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            counter_enable_status <= 1'b0;
        else if (soft_rst)
            counter_enable_status <= 1'b0;
        else if (wr_at(`RTCC_OFS_STATUS) && stat_wr_allowed)
            counter_enable_status <= bus_req.wdata[`RTCC_ST_TCE];
    end

    // =================================================================
    // interrupt: sticky events, write-one clear, new event wins
    rtcc_pkg::rtcc_evt_t evt;
    rtcc_pkg::rtcc_evt_t clr;

    assign evt = {boundary & (comp_interval_counter == 8'h00),
                  boundary,
                  boundary & (seconds_count == 32'hffff_ffff)};
    assign clr = wr_at(`RTCC_OFS_IRQ_CLR) ? bus_req.wdata[2:0] : 3'h0;

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            irq_stat_reg <= 3'h0;
        else if (soft_rst)
            irq_stat_reg <= 3'h0;
        else
            irq_stat_reg <= (irq_stat_reg & ~clr) | evt;
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            irq_en_reg <= 3'h0;
        else if (soft_rst)
            irq_en_reg <= 3'h0;
        else if (wr_at(`RTCC_OFS_IRQ_EN))
            irq_en_reg <= bus_req.wdata[2:0];
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            irq <= 1'b0;
        else
            irq <= |(irq_stat_reg & irq_en_reg);
    end

    // =================================================================
    // read mux; time reads zero while invalid or overflowed
    always_comb
    begin
        rdata_next = 32'h0000_0000;
        unique case (bus_req.addr)
            `RTCC_OFS_SECONDS:
                if (!(time_invalid_flag | time_overflow_flag))
                    rdata_next = seconds_count;
            `RTCC_OFS_PRESCALER:
                if (!(time_invalid_flag | time_overflow_flag))
                    rdata_next = 32'(prescaler_count);
            `RTCC_OFS_COMP:
                rdata_next = {comp_interval_counter, current_comp_value,
                              comp_interval_setting, comp_value_setting};
            `RTCC_OFS_CTRL:
                rdata_next = ctrl_reg;
            `RTCC_OFS_STATUS:
                rdata_next = {27'h0, counter_enable_status, 2'h0,
                              time_overflow_flag, time_invalid_flag};
            `RTCC_OFS_LOCK:
                rdata_next = {24'h0, lock_reg};
            `RTCC_OFS_IRQ_STAT:
                rdata_next = {29'h0, irq_stat_reg};
            `RTCC_OFS_IRQ_EN:
                rdata_next = {29'h0, irq_en_reg};
            default:
                rdata_next = 32'h0000_0000;
        endcase
    end

    // read data and error answer one cycle after the strobe
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            bus_rdata <= 32'h0000_0000;
            bus_error <= 1'b0;
        end
        else
        begin
            bus_rdata <= bus_req.rd ? rdata_next : 32'h0000_0000;
            bus_error <= bus_req.wr & ~wr_ok;
        end
    end

    // =================================================================
    // oscillator controls and clock forwarding
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            osc_enable   <= 1'b0;
            osc_load_sel <= 4'h0;
            clk32_fwd    <= 1'b0;
        end
        else
        begin
            osc_enable   <= ctrl_reg.oscillator_enable;
            // bit 0 is the 16 pF load, bit 3 the 2 pF load
            osc_load_sel <= ctrl_reg.load_caps;
            clk32_fwd    <= osc_q & ctrl_reg.oscillator_enable
                          & ~ctrl_reg.clock_forward_gate;
        end
    end

    // wakeup pin: open drain low, or a push of the forwarded clock
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wakeup_o  <= 1'b0;
            wakeup_oe <= 1'b0;
        end
        else if (ctrl_reg.wakeup_output_select)
        begin
            wakeup_o  <= clk32_fwd;
            wakeup_oe <= ctrl_reg.wakeup_pin_enable
                       & ~ctrl_reg.clock_forward_gate;
        end
        else
        begin
            wakeup_o  <= 1'b0;
            wakeup_oe <= ctrl_reg.wakeup_pin_enable
                       & (|(irq_stat_reg & irq_en_reg) | wakeup_turn_on);
        end
    end
endmodule // rtcc_top
